/* File: common/i2c_ctl_pkg.sv */
// Function
// - Works at 100 kHz and 400 kHz
// - Slave only, never starts transfers
// - Never holds SCL low
// - Bytes MSB first, receiver acknowledges
// - SDA fall/rise while SCL high: start/stop
// - Driven SDA changes only while SCL low
// - Acknowledge holds SDA low whole clock
// - Answers only its seven-bit address
// - Any byte count between start and stop
// - Processing registers take four-byte words
// - Reads stream on; unused bits read zero
// - Biquad needs five words, else discarded
// - Mixer coefficient needs one whole word
// - Sequential writes step through subaddresses
// - Only incomplete final subaddress is dropped
// - Write: address, subaddress, data, all acknowledged
// - Every data byte of writes acknowledged
// - Read: subaddress write, repeated start, read
// - Works without the audio master clock
package i2c_ctl_pkg;

    // Seven-bit form of the write address byte 8'h36
    localparam logic [6:0] SLAVE_ADDR7 = 7'h1B;

    localparam logic [7:0] SUB_WORD_FIRST = 8'h20;
    localparam logic [7:0] SUB_BIQUAD_FIRST = 8'h29;
    localparam logic [7:0] SUB_BIQUAD_LAST = 8'h3F;

    localparam logic [4:0] SIZE_GENERAL = 5'h01;
    localparam logic [4:0] SIZE_WORD = 5'h04;
    localparam logic [4:0] SIZE_BIQUAD = 5'h14;

    localparam logic [31:0] MASK_GENERAL = 32'h0000_00FF;
    localparam logic [31:0] MASK_WORD = 32'hFFFF_FFFF;

    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int DATA_W = 160;

    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } bus_ev_t;

    typedef struct packed {
        logic valid;
        logic [7:0] sub;
        logic [4:0] nbytes;
        logic [DATA_W-1:0] data;
    } wr_cmd_t;

    // Bytes that make one complete set for a subaddress
    function automatic logic [4:0] size_bytes(input logic [7:0] sub);
        if (sub < SUB_WORD_FIRST) begin
            return SIZE_GENERAL;
        end else if (sub >= SUB_BIQUAD_FIRST && sub <= SUB_BIQUAD_LAST) begin
            return SIZE_BIQUAD;
        end
        return SIZE_WORD;
    endfunction

    function automatic logic [31:0] rd_mask(input logic [7:0] sub);
        if (sub < SUB_WORD_FIRST) begin
            return MASK_GENERAL;
        end
        return MASK_WORD;
    endfunction

endpackage

/* File: verilog/i2c_bus_sense.sv */
module i2c_bus_sense (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output i2c_ctl_pkg::bus_ev_t o_ev
);

    // Index 1 is SCL, index 0 is SDA
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
            prev_q <= 2'h3;
        end else begin
            meta_q <= {i_scl, i_sda};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    always_comb begin
        o_ev.scl = sync_q[1];
        o_ev.sda = sync_q[0];
        o_ev.scl_rise = sync_q[1] & ~prev_q[1];
        o_ev.scl_fall = ~sync_q[1] & prev_q[1];
        o_ev.start = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
        o_ev.stop = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];
    end

    a_start_cond: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_ev.start |-> o_ev.scl && !o_ev.sda && $past(o_ev.sda))
        else $error("start seen without SCL high and SDA falling");

endmodule

/* File: verilog/i2c_write_collect.sv */
module i2c_write_collect (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_clear,
    input wire logic i_byte_vld,
    input wire logic [7:0] i_byte,
    input wire logic [7:0] i_sub,
    input wire logic [4:0] i_size,
    output i2c_ctl_pkg::wr_cmd_t o_wr
);

    logic [4:0] cnt_q;
    logic [i2c_ctl_pkg::DATA_W-1:0] data_q;
    logic last;

    assign last = (cnt_q == i_size - 5'h01);

    // Partial sets are thrown away at any start or stop
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 5'h00;
            data_q <= '0;
        end else if (i_clear) begin
            cnt_q <= 5'h00;
            data_q <= '0;
        end else if (i_byte_vld) begin
            if (last) begin
                cnt_q <= 5'h00;
                data_q <= '0;
            end else begin
                cnt_q <= cnt_q + 5'h01;
                data_q <= {data_q[i2c_ctl_pkg::DATA_W-9:0], i_byte};
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wr <= '0;
        end else begin
            o_wr.valid <= i_byte_vld && !i_clear && last;
            if (i_byte_vld && last) begin
                o_wr.sub <= i_sub;
                o_wr.nbytes <= i_size;
                o_wr.data <= {data_q[i2c_ctl_pkg::DATA_W-9:0], i_byte};
            end
        end
    end

    a_commit_count: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_byte_vld && !i_clear && cnt_q == i_size - 5'h01) |=> o_wr.valid && cnt_q == 5'h00)
        else $error("complete set not committed");

    a_discard_part: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        i_clear |=> cnt_q == 5'h00 && !o_wr.valid)
        else $error("partial set survived a start or stop");

endmodule

/* File: verilog/i2c_control_slave.sv */
module i2c_control_slave (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output i2c_ctl_pkg::wr_cmd_t o_wr,
    output logic [7:0] o_rd_sub,
    output logic [2:0] o_rd_word,
    input wire logic [31:0] i_rd_word
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_RX_END,
        S_ACK,
        S_TX,
        S_TX_ACK,
        S_TX_NEXT,
        S_IGNORE
    } state_t;

    typedef enum logic [1:0] {
        P_ADDR,
        P_SUB,
        P_DATA
    } phase_t;

    i2c_ctl_pkg::bus_ev_t ev;
    state_t state_q;
    phase_t phase_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic rw_q;
    logic [7:0] sub_q;
    logic [4:0] byte_idx_q;
    logic [7:0] tx_q;
    logic sda_oe_q;
    logic rx_done;
    logic [7:0] rx_byte;
    logic addr_match;
    logic data_vld;
    logic tx_load;
    logic [4:0] size;
    logic [31:0] rd_masked;
    logic [1:0] rd_sel;
    logic [7:0] rd_byte;

    // Only the system clock is used; no audio clock is needed
    i2c_bus_sense u_sense (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_ev(ev)
    );

    i2c_write_collect u_collect (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_clear(ev.start || ev.stop),
        .i_byte_vld(data_vld),
        .i_byte(rx_byte),
        .i_sub(sub_q),
        .i_size(size),
        .o_wr(o_wr)
    );

    assign size = i2c_ctl_pkg::size_bytes(sub_q);
    assign rx_done = (state_q == S_RX) && ev.scl_rise && (bit_cnt_q == i2c_ctl_pkg::BIT_LAST);
    assign rx_byte = {shift_q, ev.sda};
    assign addr_match = (rx_byte[7:1] == i2c_ctl_pkg::SLAVE_ADDR7);
    assign data_vld = rx_done && (phase_q == P_DATA);
    assign tx_load = ev.scl_fall && !ev.start && !ev.stop &&
        ((state_q == S_ACK && phase_q == P_ADDR && rw_q) || state_q == S_TX_NEXT);

    // Read path: unused high bits of narrow registers return zero
    assign o_rd_sub = sub_q;
    assign o_rd_word = byte_idx_q[4:2];
    assign rd_masked = i_rd_word & i2c_ctl_pkg::rd_mask(sub_q);
    assign rd_sel = 2'h3 - byte_idx_q[1:0];
    assign rd_byte = (size == i2c_ctl_pkg::SIZE_GENERAL) ? rd_masked[7:0] : rd_masked[{rd_sel, 3'h0} +: 8];

    // Open drain: the pin is only ever pulled low, SCL is never driven
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe_q;

    // Bus state; start and stop override everything
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= S_IDLE;
        end else if (ev.stop) begin
            state_q <= S_IDLE;
        end else if (ev.start) begin
            state_q <= S_RX;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    state_q <= S_IDLE;
                end
                S_RX: begin
                    if (rx_done) begin
                        if (phase_q == P_ADDR && !addr_match) begin
                            state_q <= S_IGNORE;
                        end else begin
                            state_q <= S_RX_END;
                        end
                    end
                end
                S_RX_END: begin
                    if (ev.scl_fall) begin
                        state_q <= S_ACK;
                    end
                end
                S_ACK: begin
                    if (ev.scl_fall) begin
                        state_q <= tx_load ? S_TX : S_RX;
                    end
                end
                S_TX: begin
                    if (ev.scl_fall && bit_cnt_q == i2c_ctl_pkg::BIT_LAST) begin
                        state_q <= S_TX_ACK;
                    end
                end
                S_TX_ACK: begin
                    if (ev.scl_rise) begin
                        state_q <= ev.sda ? S_IGNORE : S_TX_NEXT;
                    end
                end
                S_TX_NEXT: begin
                    if (ev.scl_fall) begin
                        state_q <= S_TX;
                    end
                end
                S_IGNORE: begin
                    state_q <= S_IGNORE;
                end
            endcase
        end
    end

    // Transfer phase and direction
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_q <= P_ADDR;
            rw_q <= 1'b0;
        end else if (ev.start || ev.stop) begin
            phase_q <= P_ADDR;
        end else if (rx_done && phase_q == P_ADDR && addr_match) begin
            rw_q <= rx_byte[0];
            phase_q <= rx_byte[0] ? P_ADDR : P_SUB;
        end else if (rx_done && phase_q == P_SUB) begin
            phase_q <= P_DATA;
        end
    end

    // Bit counter and receive shifter
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
        end else if (ev.start || ev.stop) begin
            bit_cnt_q <= 3'h0;
        end else if (state_q == S_RX && ev.scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= rx_byte[6:0];
        end else if (state_q == S_TX && ev.scl_fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end else if (state_q == S_ACK || state_q == S_TX_NEXT) begin
            bit_cnt_q <= 3'h0;
        end
    end

    // Subaddress pointer: set by the subaddress byte, stepped per complete set
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sub_q <= 8'h00;
            byte_idx_q <= 5'h00;
        end else if (ev.start) begin
            byte_idx_q <= 5'h00;
        end else if (rx_done && phase_q == P_SUB) begin
            sub_q <= rx_byte;
            byte_idx_q <= 5'h00;
        end else if (o_wr.valid) begin
            sub_q <= sub_q + 8'h01;
        end else if (tx_load) begin
            if (byte_idx_q == size - 5'h01) begin
                byte_idx_q <= 5'h00;
                sub_q <= sub_q + 8'h01;
            end else begin
                byte_idx_q <= byte_idx_q + 5'h01;
            end
        end
    end

    // Transmit shifter, moved on SCL falls only
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_q <= 8'hFF;
        end else if (tx_load) begin
            tx_q <= rd_byte;
        end else if (state_q == S_TX && ev.scl_fall) begin
            tx_q <= {tx_q[6:0], 1'b1};
        end
    end

    // SDA pull-down, registered from state and the transmit shifter MSB
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sda_oe_q <= 1'b0;
        end else begin
            sda_oe_q <= (state_q == S_ACK) || (state_q == S_TX && !tx_q[7]);
        end
    end

    a_start_rx: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        ev.start |=> state_q == S_RX && bit_cnt_q == 3'h0 && phase_q == P_ADDR)
        else $error("start did not restart address reception");

    a_stop_idle: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        ev.stop |=> state_q == S_IDLE ##1 !o_sda_oe)
        else $error("stop did not return to idle");

    a_ack_held_low: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_q == S_ACK && $past(state_q) == S_ACK) |-> o_sda_oe)
        else $error("acknowledge not held low");

    a_ignore_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_q == S_IGNORE && $past(state_q) == S_IGNORE) |-> !o_sda_oe)
        else $error("SDA driven while ignoring");

    a_sda_scl_low: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        $changed(o_sda_oe) |-> !ev.scl)
        else $error("SDA changed while SCL high");

    a_addr_match: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (rx_done && phase_q == P_ADDR && !ev.stop && !ev.start) |=>
            (state_q == S_RX_END) == ($past(rx_byte[7:1]) == i2c_ctl_pkg::SLAVE_ADDR7))
        else $error("address match decision wrong");

    a_sub_step: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (o_wr.valid && !ev.start) |=> sub_q == $past(sub_q) + 8'h01)
        else $error("subaddress did not advance after complete set");

    a_read_step: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (tx_load && byte_idx_q == size - 5'h01) |=> byte_idx_q == 5'h00 && sub_q == $past(sub_q) + 8'h01)
        else $error("read pointer did not advance");

    a_idle_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_q == S_IDLE && $past(state_q) == S_IDLE) |-> !o_sda_oe)
        else $error("SDA driven while idle");

    a_ack_after_byte: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_q == S_RX_END && ev.scl_fall && !ev.start && !ev.stop) |-> ##2 o_sda_oe)
        else $error("received byte not acknowledged");

    a_ack_release: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_q == S_ACK && ev.scl_fall && !tx_load) |-> ##2 !o_sda_oe)
        else $error("acknowledge not released after its clock");

    a_tx_release: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_q == S_TX && ev.scl_fall && bit_cnt_q == i2c_ctl_pkg::BIT_LAST) |-> ##2 !o_sda_oe)
        else $error("SDA not released for master acknowledge");

    a_nack_release: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_q == S_TX_ACK && ev.scl_rise && ev.sda) |=> state_q == S_IGNORE ##1 !o_sda_oe [*4])
        else $error("read went on after master not-acknowledge");

    a_ignore_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_q == S_IGNORE && !ev.start && !ev.stop) |=> state_q == S_IGNORE)
        else $error("ignored transaction resumed without start or stop");

    a_write_dir: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        data_vld |-> !rw_q)
        else $error("data byte taken in read direction");

    a_read_dir: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        tx_load |-> rw_q)
        else $error("read byte loaded in write direction");

    a_commit_size: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_wr.valid |-> o_wr.nbytes == i2c_ctl_pkg::size_bytes(o_wr.sub))
        else $error("committed set size does not fit subaddress");

    a_sub_load: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (rx_done && phase_q == P_SUB && !ev.start && !ev.stop) |=> sub_q == $past(rx_byte) && byte_idx_q == 5'h00)
        else $error("subaddress byte not loaded");

    a_stop_clears: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        ev.stop |=> bit_cnt_q == 3'h0 && phase_q == P_ADDR)
        else $error("stop left a partial byte behind");

    c_write_commit: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) o_wr.valid);
    c_read_byte: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) tx_load ##[1:1000] tx_load);
    c_mismatch: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        rx_done && phase_q == P_ADDR && !addr_match);
    c_nack_end: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        state_q == S_TX_ACK && ev.scl_rise && ev.sda);
    c_biquad_commit: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_wr.valid && o_wr.nbytes == i2c_ctl_pkg::SIZE_BIQUAD);

endmodule

/* File: tb/ctl_master_model.sv */
module ctl_master_model (
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    int hold = 0;

    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    // One clock pulse; data moves in low time, sampled late in high time
    task automatic bit_io(input logic b, output logic r);
        o_scl <= 1'b0;
        tick(1);
        o_sda_low <= ~b;
        tick(3 + hold);
        o_scl <= 1'b1;
        tick(3 + hold);
        r = i_sda;
        tick(1);
    endtask

    // Start or stop: data edge while clock high
    task automatic cond(input logic stop);
        o_scl <= 1'b0;
        tick(1);
        o_sda_low <= stop;
        tick(3 + hold);
        o_scl <= 1'b1;
        tick(4 + hold);
        o_sda_low <= ~stop;
        tick(4 + hold);
    endtask

    // Byte MSB first, then the acknowledge clock
    task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] r, output logic ack_low);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], x);
            r[i] = x;
        end
        bit_io(~m_ack, x);
        ack_low = ~x;
    endtask
endmodule

/* File: tb/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic arst_n;
    logic scl;
    logic sda_low;
    logic sda;
    logic oe;
    logic sda_out;
    logic [31:0] rd_word;
    logic [7:0] rd_sub;
    logic [2:0] rd_idx;
    i2c_ctl_pkg::wr_cmd_t wr;
    logic [172:0] got_q[$];
    logic [172:0] exp_q[$];
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int hits = 0;
    logic watch = 1'b0;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    assign sda = (sda_low || (oe && !sda_out)) ? 1'b0 : 1'b1;

    i2c_control_slave DUT (
        .i_clk_sys(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
        .o_sda_oe(oe), .o_wr(wr), .o_rd_sub(rd_sub), .o_rd_word(rd_idx), .i_rd_word(rd_word)
    );

    ctl_master_model MST (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

    // Register file stand-in: answers the read pointer in the same cycle
    assign rd_word = {rd_sub, 5'h00, rd_idx, ~rd_sub, rd_sub ^ 8'h5A};

    always @(posedge clk) begin
        if (wr.valid === 1'b1) begin
            got_q.push_back(wr[172:0]);
        end
        if (watch && oe !== 1'b0) begin
            hits++;
        end
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            $display("unexpected %0t run did not finish", $time);
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %0t bit %b want %b", $time, g, e);
        end
    endtask

    task automatic chk_v(input logic [172:0] g, input logic [172:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %0t value %h want %h", $time, g, e);
        end
    endtask

    task automatic wr_b(input logic [7:0] d, input logic e_ack);
        logic [7:0] r;
        logic a;
        MST.xfer(d, 1'b0, r, a);
        chk_bit(a, e_ack);
    endtask

    task automatic rd_b(input logic m_ack, input logic [7:0] e);
        logic [7:0] r;
        logic a;
        MST.xfer(8'hFF, m_ack, r, a);
        chk_v(173'(r), 173'(e));
    endtask

    task automatic push(input logic [7:0] s, input logic [4:0] n, input logic [159:0] d);
        exp_q.push_back({s, n, d});
    endtask

    task automatic open(input logic [7:0] s);
        MST.cond(1'b0);
        wr_b(8'h36, 1'b1);
        wr_b(s, 1'b1);
    endtask

    // Stop, then every commit seen must match the expected list
    task automatic close();
        MST.cond(1'b1);
        repeat (8) @(posedge clk);
        chk_bit(oe, 1'b0);
        chk_v(173'(got_q.size()), 173'(exp_q.size()));
        foreach (exp_q[i]) begin
            chk_v(got_q[i], exp_q[i]);
        end
        got_q.delete();
        exp_q.delete();
    endtask

    task automatic t_single();
        open(8'h05);
        wr_b(8'hA7, 1'b1);
        push(8'h05, 5'h01, 160'hA7);
        close();
    endtask

    task automatic t_seq();
        open(8'h1E);
        wr_b(8'h11, 1'b1);
        wr_b(8'h22, 1'b1);
        wr_b(8'hDE, 1'b1);
        wr_b(8'hAD, 1'b1);
        wr_b(8'hBE, 1'b1);
        wr_b(8'hEF, 1'b1);
        wr_b(8'h01, 1'b1);
        wr_b(8'h02, 1'b1);
        push(8'h1E, 5'h01, 160'h11);
        push(8'h1F, 5'h01, 160'h22);
        push(8'h20, 5'h04, 160'hDEADBEEF);
        close();
    endtask

    task automatic t_biquad();
        logic [159:0] e;
        e = '0;
        open(8'h29);
        for (int i = 1; i < 20; i++) begin
            wr_b(8'(i), 1'b1);
        end
        open(8'h29);
        for (int i = 1; i <= 20; i++) begin
            wr_b(8'(i + 8'h40), 1'b1);
            e = {e[151:0], 8'(i + 8'h40)};
        end
        push(8'h29, 5'h14, e);
        close();
    endtask

    task automatic t_read();
        open(8'h20);
        MST.cond(1'b0);
        wr_b(8'h37, 1'b1);
        rd_b(1'b1, 8'h20);
        rd_b(1'b1, 8'h00);
        rd_b(1'b1, 8'hDF);
        rd_b(1'b1, 8'h7A);
        rd_b(1'b0, 8'h21);
        close();
        open(8'h10);
        MST.cond(1'b0);
        wr_b(8'h37, 1'b1);
        rd_b(1'b1, 8'h4A);
        rd_b(1'b0, 8'h4B);
        close();
        open(8'h29);
        MST.cond(1'b0);
        wr_b(8'h37, 1'b1);
        rd_b(1'b1, 8'h29);
        rd_b(1'b1, 8'h00);
        rd_b(1'b1, 8'hD6);
        rd_b(1'b1, 8'h73);
        rd_b(1'b1, 8'h29);
        rd_b(1'b0, 8'h01);
        close();
    endtask

    task automatic t_nomatch();
        watch = 1'b1;
        MST.cond(1'b0);
        wr_b(8'h38, 1'b0);
        wr_b(8'h05, 1'b0);
        wr_b(8'h99, 1'b0);
        watch = 1'b0;
        chk_v(173'(hits), 173'(0));
        close();
    endtask

    task automatic t_rates();
        int h[2] = '{246, 58};
        foreach (h[i]) begin
            MST.hold = h[i];
            open(8'h07);
            wr_b(8'h30, 1'b1);
            push(8'h07, 5'h01, 160'h30);
            close();
        end
        MST.hold = 0;
    endtask

    initial begin
        arst_n = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_single();
        t_seq();
        t_biquad();
        t_read();
        t_nomatch();
        t_rates();
        end_sim();
    end
endmodule
